/* File: verilog/csda_params.svh */
`ifndef CSDA_PARAMS_SVH
`define CSDA_PARAMS_SVH
// instruction encodings
`define CSDA_OP_CMP_LESS     7'h30
`define CSDA_OP_DEC_ADJ      16'h0007
// field positions
`define CSDA_OPC_MSB         15
`define CSDA_OPC_LSB         9
`define CSDA_BANK_BIT        8
// apb register offsets
`define CSDA_REG_INSTR       12'h000
`define CSDA_REG_WORK        12'h004
`define CSDA_REG_FLAGS       12'h008
`define CSDA_REG_DATA        12'h00c
`define CSDA_REG_STATUS      12'h010
`define CSDA_REG_BANK        12'h014
// flag register fields
`define CSDA_FLAG_CARRY      0
`define CSDA_FLAG_DIGIT      1
// status register fields
`define CSDA_ST_BUSY         0
`define CSDA_ST_SKIP         1
`define CSDA_ST_BANKSEL      2
`define CSDA_ST_ILLEGAL      3
// reset values
`define CSDA_RST_WORK        8'h00
`define CSDA_RST_BANK        4'h0
// timing counts: last q phase index, skip lengths in instruction cycles
`define CSDA_Q_PHASES        2'h3
`define CSDA_CYC_SKIP1       2'h1
`define CSDA_CYC_SKIP2       2'h2
`endif

/* File: verilog/csda_pkg.sv */
package csda_pkg;
	typedef enum logic [1:0]
	{
		CSDA_IDLE = 2'b00,
		CSDA_EXEC = 2'b01,
		CSDA_SKIP = 2'b10
	} csda_state_t;
	typedef enum logic [1:0]
	{
		CSDA_OP_NONE = 2'b00,
		CSDA_OP_CMP  = 2'b01,
		CSDA_OP_DAW  = 2'b10
	} csda_op_t;
endpackage

/* File: verilog/csda_alu.sv */
`timescale 1ns/1ps
`include "csda_params.svh"
// combinational decimal adjust and compare
module csda_alu
	import csda_pkg::*;
(
	input  wire logic [7:0] work_in,
	input  wire logic [7:0] data_in,
	input  wire logic       carry_in,
	input  wire logic       digit_in,
	output logic      [7:0] adj_out,
	output logic            carry_out,
	output logic            less_out
);
	logic [4:0] lo_sum;
	logic [4:0] hi_base;
	logic [4:0] hi_sum;
	logic [8:0] diff;

	// low nibble correction
	// low nibble fix
	always_comb
	begin
		if ((work_in[3:0] > 4'h9) || digit_in)
			lo_sum = {1'b0, work_in[3:0]} + 5'h06;
		else
			lo_sum = {1'b0, work_in[3:0]};
	end

	// high nibble correction with digit carry
	// high nibble fix
	always_comb
	begin
		hi_base = {1'b0, work_in[7:4]} + {4'h0, digit_in};
		if ((hi_base > 5'h09) || carry_in)
			hi_sum = hi_base + 5'h06;
		else
			hi_sum = hi_base;
	end

	assign adj_out   = {hi_sum[3:0], lo_sum[3:0]};
	assign carry_out = hi_sum[4] | carry_in;

	// unsigned subtraction, borrow means data below work
	// unsigned compare
	assign diff     = {1'b0, data_in} - {1'b0, work_in};
	assign less_out = diff[8];
endmodule // csda_alu

/* File: verilog/csda_core.sv */
`timescale 1ns/1ps
`include "csda_params.svh"
//Contract
// - compare-skip-if-less opcode is 0110000 then bank bit and 8-bit address
// - register address ranges 0 to 255, bank bit optional, default one
// - skip only when data byte is unsigned strictly less than working register
// - on skip, fetched instruction becomes no-operation; no flag or register changes
// - one cycle no skip, two on skip, three skipping two-word instruction
// - bank bit zero uses access bank, one uses bank select register
// - decimal adjust is fixed word 0007h, one cycle, reads and writes working register
// - high nibble gets six plus digit carry when sum above nine or carry
// - decimal adjust yields packed bcd; only carry flag may change
module csda_core
	import csda_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [11:0] data_addr,
	output logic             skip_active
);
	csda_state_t state;
	csda_op_t    op;
	logic [15:0] instr;
	logic [7:0]  work;
	logic        carry;
	logic        digit;
	logic [7:0]  data_byte;
	logic [3:0]  bank_sel;
	logic        next_is_long;
	logic [1:0]  qph;
	logic [1:0]  skip_left;
	logic        illegal;
	logic        did_skip;
	logic [7:0]  adj_val;
	logic        adj_carry;
	logic        is_less;
	logic        wr_acc;
	logic        rd_acc;
	logic        start;
	logic        decoded_cmp;
	logic        decoded_daw;

	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite;
	assign start  = wr_acc && (paddr == `CSDA_REG_INSTR) && (state == CSDA_IDLE);

	assign decoded_cmp = (pwdata[`CSDA_OPC_MSB:`CSDA_OPC_LSB] == `CSDA_OP_CMP_LESS);
	assign decoded_daw = (pwdata[15:0] == `CSDA_OP_DEC_ADJ);

	csda_alu i_csda_alu
	(
		.work_in   (work),
		.data_in   (data_byte),
		.carry_in  (carry),
		.digit_in  (digit),
		.adj_out   (adj_val),
		.carry_out (adj_carry),
		.less_out  (is_less)
	);

	// instruction latch and decode
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			instr   <= 16'h0000;
			op      <= CSDA_OP_NONE;
			illegal <= 1'b0;
			next_is_long <= 1'b0;
		end
		else if (start)
		begin
			instr        <= pwdata[15:0];
			next_is_long <= pwdata[16];
			if (decoded_cmp)
			begin
				op      <= CSDA_OP_CMP;
				illegal <= 1'b0;
			end
			else if (decoded_daw)
			begin
				op      <= CSDA_OP_DAW;
				illegal <= 1'b0;
			end
			else
			begin
				op      <= CSDA_OP_NONE;
				illegal <= 1'b1;
			end
		end
	end

	// four-phase sequencer and skip cycles
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state     <= CSDA_IDLE;
			qph       <= 2'h0;
			skip_left <= 2'h0;
			did_skip  <= 1'b0;
		end
		else
		begin
			unique case (state)
				CSDA_IDLE:
				begin
					if (start)
					begin
						state    <= CSDA_EXEC;
						qph      <= 2'h0;
						did_skip <= 1'b0;
					end
				end
				CSDA_EXEC:
				begin
					qph <= qph + 2'h1;
					if (qph == `CSDA_Q_PHASES)
					begin
						qph <= 2'h0;
						if (op == CSDA_OP_CMP && is_less)
						begin
							state     <= CSDA_SKIP;
							did_skip  <= 1'b1;
							skip_left <= next_is_long ? `CSDA_CYC_SKIP2 : `CSDA_CYC_SKIP1;
						end
						else
							state <= CSDA_IDLE;
					end
				end
				CSDA_SKIP:
				begin
					qph <= qph + 2'h1;
					if (qph == `CSDA_Q_PHASES)
					begin
						qph       <= 2'h0;
						skip_left <= skip_left - 2'h1;
						if (skip_left == 2'h1)
							state <= CSDA_IDLE;
					end
				end
				default:
					state <= CSDA_IDLE;
			endcase
		end
	end

	// operand address with bank choice
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			data_addr <= 12'h000;
		else if (state == CSDA_EXEC && op == CSDA_OP_CMP && qph == 2'h0)
		begin
			if (instr[`CSDA_BANK_BIT])
				data_addr <= {bank_sel, instr[7:0]};
			else
				data_addr <= {{4{instr[7]}}, instr[7:0]};
		end
	end

	// working register and carry flags; compare writes none
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			work  <= `CSDA_RST_WORK;
			carry <= 1'b0;
			digit <= 1'b0;
		end
		else if (state == CSDA_EXEC && op == CSDA_OP_DAW && qph == `CSDA_Q_PHASES)
		begin
			work  <= adj_val;
			carry <= adj_carry;
		end
		else if (state == CSDA_IDLE && wr_acc && paddr == `CSDA_REG_WORK)
			work <= pwdata[7:0];
		else if (state == CSDA_IDLE && wr_acc && paddr == `CSDA_REG_FLAGS)
		begin
			carry <= pwdata[`CSDA_FLAG_CARRY];
			digit <= pwdata[`CSDA_FLAG_DIGIT];
		end
	end

	// data byte and bank select loaded by software
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			data_byte <= 8'h00;
			bank_sel  <= `CSDA_RST_BANK;
		end
		else if (state == CSDA_IDLE && wr_acc && paddr == `CSDA_REG_DATA)
			data_byte <= pwdata[7:0];
		else if (state == CSDA_IDLE && wr_acc && paddr == `CSDA_REG_BANK)
			bank_sel <= pwdata[3:0];
	end

	// skip output
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			skip_active <= 1'b0;
		else
			skip_active <= (state == CSDA_SKIP);
	end

	// apb slave: no wait states, reads registered
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable)
			begin
				prdata <= 32'h0000_0000;
				unique case (paddr)
					`CSDA_REG_INSTR:  prdata <= {16'h0000, instr};
					`CSDA_REG_WORK:   prdata <= {24'h000000, work};
					`CSDA_REG_FLAGS:  prdata <= {30'h0, digit, carry};
					`CSDA_REG_DATA:   prdata <= {24'h000000, data_byte};
					`CSDA_REG_STATUS: prdata <= {28'h0, illegal, instr[`CSDA_BANK_BIT],
						did_skip, (state != CSDA_IDLE)};
					`CSDA_REG_BANK:   prdata <= {28'h0, bank_sel};
					default:
					begin
						prdata  <= 32'h0000_0000;
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

	a_cmp_keeps_flags: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(state == CSDA_EXEC && op == CSDA_OP_CMP) |=> $stable(carry) && $stable(work))
		else $error("compare changed working register or carry");

	a_daw_one_cycle: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(state == CSDA_IDLE && start && decoded_daw) |=> (state == CSDA_EXEC) [*4]
		##1 (state == CSDA_IDLE))
		else $error("adjust did not finish in one instruction cycle");

	a_skip_length: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(state == CSDA_SKIP) && skip_left == 2'h1 |-> (state == CSDA_SKIP) [*4]
		##1 (state == CSDA_IDLE))
		else $error("single skip length wrong");

	// long skip takes two more cycles
	a_skip_long: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(state == CSDA_SKIP) && skip_left == 2'h2 |-> (state == CSDA_SKIP) [*8]
		##1 (state == CSDA_IDLE))
		else $error("long skip length wrong");

	a_skip_cause: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(state == CSDA_SKIP) |-> $past(is_less) && op == CSDA_OP_CMP)
		else $error("skip without data below working register");

	a_no_skip: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(state == CSDA_EXEC && qph == 2'h3 && !is_less) |=> state == CSDA_IDLE)
		else $error("skipped although data not below working register");

	a_daw_result: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(state == CSDA_EXEC && op == CSDA_OP_DAW && qph == 2'h3)
		|=> work == $past(adj_val) && carry == $past(adj_carry))
		else $error("adjust result not written");

	a_daw_example: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(work == 8'ha5 && !carry && !digit) |-> adj_val == 8'h05 && adj_carry)
		else $error("adjust of a5 wrong");

	a_daw_high: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(carry && !digit && work[7:4] < 4'h4) |-> adj_val[7:4] == work[7:4] + 4'h6)
		else $error("high nibble correction missing");

	a_bank_addr: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(state == CSDA_EXEC && op == CSDA_OP_CMP && qph == 2'h0 && instr[8])
		|=> data_addr == {bank_sel, instr[7:0]})
		else $error("bank select not used");

	c_daw_run:   cover property (@(posedge sys_clk) state == CSDA_EXEC && op == CSDA_OP_DAW);
	c_skip_one:  cover property (@(posedge sys_clk) $rose(state == CSDA_SKIP) && skip_left == 2'h1);
	c_skip_two:  cover property (@(posedge sys_clk) $rose(state == CSDA_SKIP) && skip_left == 2'h2);
	c_no_skip:   cover property (@(posedge sys_clk) state == CSDA_EXEC && qph == 2'h3 && !is_less
		&& op == CSDA_OP_CMP);
endmodule // csda_core

/* File: testbench/compare_skip_decimal_adjust_tb.sv */
`timescale 1ns/1ps
`include "csda_params.svh"
module compare_skip_decimal_adjust_tb
	import csda_pkg::*;
;
	typedef struct {logic [31:0] exp; logic [31:0] msk; logic err;} csda_note_t;
	logic        sys_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd_data;
	logic        pready;
	logic        pslverr;
	logic [11:0] data_addr;
	logic        skip_active;
	csda_note_t  notes[$];
	csda_note_t  cur;
	int          err_count   = 0;
	int          comparisons = 0;
	int          skip_cnt    = 0;

	csda_core i_csda_core
	(
		.sys_clk     (sys_clk),
		.reset_n     (reset_n),
		.psel        (psel),
		.penable     (penable),
		.pwrite      (pwrite),
		.paddr       (paddr),
		.pwdata      (pwdata),
		.prdata      (prdata),
		.pready      (pready),
		.pslverr     (pslverr),
		.data_addr   (data_addr),
		.skip_active (skip_active)
	);

	// 20 mhz clock
	initial
	begin
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_sim();
		if (err_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// one apb transfer, expectation noted first
	task automatic apb(input logic is_wr, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic [31:0] m, input logic er);
		int n;
		notes.push_back('{e, m, er});
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= is_wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++)
		begin
			@(posedge sys_clk);
			if (pready === 1'b1)
				break;
		end
		rd_data = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20)
		begin
			chk(32'h0, 32'h1, "pready timeout");
			end_sim();
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(1'b0, a, 32'h0, e, m, 1'b0);
	endtask

	// poll status until the instruction has finished
	task automatic wait_idle();
		int n;
		for (n = 0; n < 30; n++)
		begin
			rd(`CSDA_REG_STATUS, 32'h0, 32'h0);
			if (rd_data[`CSDA_ST_BUSY] === 1'b0)
				break;
		end
		chk({31'h0, rd_data[`CSDA_ST_BUSY]}, 32'h0, "busy");
		if (rd_data[`CSDA_ST_BUSY] !== 1'b0)
			end_sim();
	endtask

	// decimal adjust reference: {carry, result}
	function automatic logic [8:0] daw_ref(input logic [7:0] w, input logic c, input logic dc);
		logic [3:0] lo;
		logic [4:0] hi;
		lo = (w[3:0] > 9 || dc) ? w[3:0] + 4'h6 : w[3:0];
		hi = (w[7:4] + dc > 9 || c) ? w[7:4] + 5'h6 + dc : w[7:4] + dc;
		return {c | hi[4], hi[3:0], lo};
	endfunction

	// answer watcher and skip cycle counter
	always @(posedge sys_clk)
	begin
		if (psel && penable && pready === 1'b1)
		begin
			cur = notes.pop_front();
			chk(prdata & cur.msk, cur.exp, "prdata");
			chk({31'h0, pslverr}, {31'h0, cur.err}, "pslverr");
		end
		if (skip_active === 1'b1)
			skip_cnt++;
	end

	// main sequence
	initial
	begin
		logic [7:0] w, d, f;
		logic       a, two, c, dc, less;
		logic [3:0] bank;
		logic [8:0] r;
		int         i;
		void'($urandom(85822));
		repeat (4) @(posedge sys_clk);
		reset_n <= 1'b1;
		rd(`CSDA_REG_WORK, 32'h0, 32'hff);
		rd(`CSDA_REG_STATUS, 32'h0, 32'hf);
		apb(1'b0, 12'h018, 32'h0, 32'h0, 32'h0, 1'b1);
		for (i = 0; i < 24; i++)
		begin
			w = $urandom;
			d = (i % 4 == 0) ? w : (i % 4 == 1) ? w - 8'h1 : 8'($urandom);
			{f, a, two, bank, c, dc} = 16'($urandom);
			less = d < w;
			wr(`CSDA_REG_WORK, {24'h0, w});
			wr(`CSDA_REG_FLAGS, {30'h0, dc, c});
			wr(`CSDA_REG_DATA, {24'h0, d});
			wr(`CSDA_REG_BANK, {28'h0, bank});
			skip_cnt = 0;
			wr(`CSDA_REG_INSTR, {15'h0, two, `CSDA_OP_CMP_LESS, a, f});
			wr(`CSDA_REG_WORK, {24'h0, ~w});
			wait_idle();
			chk(32'(skip_cnt), less ? (two ? 32'h8 : 32'h4) : 32'h0, "skip cycles");
			rd(`CSDA_REG_STATUS, {28'h0, 1'b0, a, less, 1'b0}, 32'hf);
			rd(`CSDA_REG_WORK, {24'h0, w}, 32'hff);
			rd(`CSDA_REG_FLAGS, {30'h0, dc, c}, 32'h3);
			chk({20'h0, data_addr}, {20'h0, a ? {bank, f} : {{4{f[7]}}, f}}, "addr");
		end
		wr(`CSDA_REG_INSTR, 32'h0000_1234);
		wait_idle();
		rd(`CSDA_REG_STATUS, 32'h8, 32'h8);
		for (i = 0; i < 24; i++)
		begin
			w = (i == 0) ? 8'ha5 : {4'($urandom), 4'($urandom_range(9, 0))};
			c = (i == 0) ? 1'b0 : 1'($urandom);
			dc = (i == 0) ? 1'b0 : 1'($urandom);
			r = daw_ref(w, c, dc);
			wr(`CSDA_REG_WORK, {24'h0, w});
			wr(`CSDA_REG_FLAGS, {30'h0, dc, c});
			skip_cnt = 0;
			wr(`CSDA_REG_INSTR, {16'h0, `CSDA_OP_DEC_ADJ});
			wait_idle();
			chk(32'(skip_cnt), 32'h0, "adjust skips");
			rd(`CSDA_REG_WORK, {24'h0, r[7:0]}, 32'hff);
			rd(`CSDA_REG_FLAGS, {30'h0, dc, r[8]}, 32'h3);
		end
		// mid-run reset returns registers to reset values
		@(posedge sys_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		rd(`CSDA_REG_WORK, {24'h0, `CSDA_RST_WORK}, 32'hff);
		rd(`CSDA_REG_FLAGS, 32'h0, 32'h3);
		rd(`CSDA_REG_STATUS, 32'h0, 32'hf);
		end_sim();
	end
endmodule // compare_skip_decimal_adjust_tb
